// ### rtl/cit_timer.v
// bit-addressed interval/event timer with indicator and i/o bits, apb slave
// assumes apb master on pclk; irq and io reset pins asynchronous, synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "cit_defs.vh"

module cit_timer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:1] irq_input_n,
   input wire io_reset_in_n,
   output reg user_indicator,
   output reg interrupt_request_flag,
   output reg [31:17] io_out,
   output reg [31:17] io_oe
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [15:1] irq_s1_reg;
   reg [15:1] irq_s2_reg;
   reg io_reset_in_n_s1_reg;
   reg io_reset_in_n_s2_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_s1_reg <= 15'h7fff;
         irq_s2_reg <= 15'h7fff;
         io_reset_in_n_s1_reg <= 1'b1;
         io_reset_in_n_s2_reg <= 1'b1;
      end else begin
         irq_s1_reg <= irq_input_n;
         irq_s2_reg <= irq_s1_reg;
         io_reset_in_n_s1_reg <= io_reset_in_n;
         io_reset_in_n_s2_reg <= io_reset_in_n_s1_reg;
      end
   end

   wire io_rst = ~io_reset_in_n_s2_reg;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready;
   wire [4:0] bidx = paddr[6:2];
   wire bit_sp = (paddr[11:7] == `CIT_BITSPACE_TOP) & (paddr[1:0] == 2'b00);
   wire multi = (paddr[11:2] == `CIT_MULTI_IDX) & (paddr[1:0] == 2'b00);
   wire stat = (paddr[11:2] == `CIT_COUNT_IDX) & (paddr[1:0] == 2'b00);
   wire mapped = bit_sp | multi | stat;
   wire wv = pwdata[0];
   wire bwr = acc & pwrite & bit_sp;
   wire mwr = acc & pwrite & multi;

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg mode_reg;
   reg [13:0] load_reg;
   reg [13:0] cnt_reg;
   reg [13:0] latch_reg;
   reg run_reg;
   reg [15:1] mask_reg;
   reg tflag_reg;

   reg mode_next;
   reg [13:0] load_next;
   reg [15:1] mask_next;
   reg start;
   reg mask3_wr;
   wire tick;

   // ----------------------------------------
   // mode, load and mask updates
   // ----------------------------------------
   always @* begin
      mode_next = mode_reg;
      load_next = load_reg;
      mask_next = mask_reg;
      start = 1'b0;
      mask3_wr = 1'b0;
      if (acc & bit_sp & bidx[4]) begin
         mode_next = 1'b0;
      end else if (bwr & (bidx == `CIT_BIT_MODE)) begin
         mode_next = wv;
      end else if (mwr) begin
         // mode plus 14 bits at once
         mode_next = pwdata[0];
         if (pwdata[0]) begin
            load_next = pwdata[14:1];
            start = 1'b1;
         end else begin
            mask_next[14:1] = pwdata[14:1];
            mask3_wr = 1'b1;
         end
      end else if (bwr & (bidx >= `CIT_BIT_TFIRST) & (bidx <= `CIT_BIT_TLAST) & mode_reg) begin
         load_next[bidx[3:0] - 4'h1] = wv;
         start = (bidx == `CIT_BIT_TLAST);
      end else if (bwr & (bidx != `CIT_BIT_MODE) & ~bidx[4] & ~mode_reg) begin
         mask_next[bidx[3:0]] = wv;
         mask3_wr = (bidx[3:0] == `CIT_BIT_TIMER_IRQ);
      end
   end

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   cit_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .restart(start),
      .tick(tick)
   );

   wire expire = run_reg & tick & (cnt_reg <= 14'h0001);
   wire tset = expire & mask_reg[`CIT_BIT_TIMER_IRQ];
   wire zero_load = start & (load_next == 14'h0000);

   // ----------------------------------------
   // counter, latch, interrupt
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `CIT_MODE_RST;
         load_reg <= `CIT_LOAD_RST;
         cnt_reg <= `CIT_LOAD_RST;
         latch_reg <= `CIT_LOAD_RST;
         run_reg <= 1'b0;
         mask_reg <= `CIT_MASK_RST;
         tflag_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         load_reg <= load_next;
         if (mode_next & ~mode_reg) begin
            latch_reg <= cnt_reg;
         end
         if (start) begin
            cnt_reg <= load_next;
            run_reg <= (load_next != 14'h0000);
         end else if (run_reg & tick) begin
            cnt_reg <= expire ? load_reg : cnt_reg - 14'h0001;
         end
         if (io_rst) begin
            mask_reg <= `CIT_MASK_RST;
         end else begin
            mask_reg <= mask_next;
            // expiry drops enable unless rewritten now
            // zero load drops only the timer enable, other levels keep theirs
            if ((expire & ~mask3_wr) | zero_load) begin
               mask_reg[`CIT_BIT_TIMER_IRQ] <= 1'b0;
            end
         end
         tflag_reg <= tset | (tflag_reg & ~(mask3_wr | io_rst | zero_load));
      end
   end

   // ----------------------------------------
   // indicator, output bits, request pin
   // ----------------------------------------
   wire soft_rst = bwr & (bidx == `CIT_BIT_SOFTRST) & mode_reg & ~wv;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_indicator <= `CIT_LED_RST;
         io_out <= 15'h0000;
         io_oe <= 15'h0000;
         interrupt_request_flag <= 1'b0;
      end else begin
         if (io_rst) begin
            user_indicator <= 1'b1;
            io_oe <= 15'h0000;
         end else if (soft_rst) begin
            user_indicator <= 1'b1;
            io_oe <= 15'h0000;
         end else if (bwr & (bidx == `CIT_BIT_LED)) begin
            user_indicator <= wv;
         end else if (bwr & bidx[4]) begin
            io_out[bidx] <= wv;
            io_oe[bidx] <= 1'b1;
         end
         interrupt_request_flag <= tflag_reg | (|(mask_reg & ~irq_s2_reg));
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   reg rd_bit;

   always @* begin
      rd_bit = 1'b0;
      if (bidx == `CIT_BIT_MODE) begin
         rd_bit = mode_reg;
      end else if (bidx == `CIT_BIT_SOFTRST) begin
         rd_bit = mode_reg ? interrupt_request_flag : irq_s2_reg[15];
      end else if (~bidx[4]) begin
         rd_bit = mode_reg ? latch_reg[bidx[3:0] - 4'h1] : irq_s2_reg[bidx[3:0]];
      end else if (bidx == `CIT_BIT_LED) begin
         rd_bit = user_indicator;
      end else if (io_oe[bidx]) begin
         rd_bit = io_out[bidx];
      end else if (bidx >= `CIT_BIT_SHARED) begin
         // bit 23 pairs with irq 15 down to bit 31 with irq 7
         rd_bit = irq_s2_reg[`CIT_SHARED_SUM - {1'b0, bidx}];
      end
   end

   // ----------------------------------------
   // apb slave, one wait-free access phase
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup & ~pready;
         if (setup) begin
            pslverr <= ~mapped;
            if (bit_sp) begin
               prdata <= {31'h0000_0000, rd_bit};
            end else if (multi) begin
               prdata <= mode_reg ? {16'h0000, interrupt_request_flag, latch_reg, 1'b1}
                                  : {16'h0000, irq_s2_reg, 1'b0};
            end else if (stat) begin
               prdata <= {18'h0_0000, cnt_reg};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end

endmodule // cit_timer

`default_nettype wire

// ### rtl/cit_defs.vh
// constants of the bit-addressed interval timer block
// assumes inclusion by bare name from the design files
`ifndef CIT_DEFS_VH
`define CIT_DEFS_VH

// ----------------------------------------
// apb map: bit space, one word per bit
// ----------------------------------------
`define CIT_BITSPACE_TOP 5'h00
`define CIT_MULTI_IDX 10'h020
`define CIT_COUNT_IDX 10'h021

// ----------------------------------------
// bit positions in the bit space
// ----------------------------------------
`define CIT_BIT_MODE 5'h00
`define CIT_BIT_TFIRST 5'h01
`define CIT_BIT_TLAST 5'h0e
`define CIT_BIT_TIMER_IRQ 4'h3
`define CIT_BIT_SOFTRST 5'h0f
`define CIT_BIT_LED 5'h10
`define CIT_BIT_SHARED 5'h17
`define CIT_SHARED_SUM 6'h26

// ----------------------------------------
// widths, timing and reset values
// ----------------------------------------
`define CIT_TW 14
`define CIT_PRESCALE 7'h40
// tick is registered, so it is raised one count early; the decrement still lands on the 64th clock
`define CIT_PRESCALE_LAST 6'h3e
`define CIT_LED_RST 1'b1
`define CIT_MODE_RST 1'b0
`define CIT_MASK_RST 15'h0000
`define CIT_LOAD_RST 14'h0000

`endif

// ### rtl/cit_prescaler.v
// divide-by-64 enable generator for the timer decrement
// assumes one clock; restart is a one-cycle pulse from the same domain
`timescale 1ns/1ps
`default_nettype none
`include "cit_defs.vh"

module cit_prescaler (
   input wire pclk,
   input wire presetn,
   input wire restart,
   output reg tick
);

   reg [5:0] div_reg;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 6'h00;
         tick <= 1'b0;
      end else if (restart) begin
         div_reg <= 6'h00;
         tick <= 1'b0;
      end else begin
         div_reg <= div_reg + 6'h01;
         tick <= (div_reg == `CIT_PRESCALE_LAST);
      end
   end

endmodule // cit_prescaler

`default_nettype wire

// ### sim/cit_timer_chk.sv
// port assertions for the bit-addressed timer
// assumes bind onto cit_timer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cit_timer_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire io_reset_in_n,
   input wire user_indicator,
   input wire interrupt_request_flag,
   input wire [31:17] io_out,
   input wire [31:17] io_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel & penable & pready;
   wire wacc = acc & pwrite;
   wire setup = psel & ~penable;
   reg mode_reg;
   // ----------------
   // mode as seen by software
   // ----------------
   // bit space above 15 drops clock mode; the two extra words do not
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_reg <= 1'b0;
      else if (wacc && (paddr == 12'h000 || paddr == 12'h080))
         mode_reg <= pwdata[0];
      else if (acc && paddr >= 12'h040 && paddr < 12'h080)
         mode_reg <= 1'b0;
   end
   apb_answer_a: assert property (setup |=> pready ##1 !pready)
      else $error("pready not one cycle");
   led_write_a: assert property (wacc && paddr == 12'h040 |=> user_indicator == $past(pwdata[0]))
      else $error("indicator not written");
   io_rst_led_a: assert property (!io_reset_in_n [*4] |=> user_indicator)
      else $error("indicator off in io reset");
   io_drive_a: assert property (wacc && paddr >= 12'h044 && paddr <= 12'h07C && paddr[1:0] == 2'h0 |=>
      io_oe[$past(paddr[6:2])] && io_out[$past(paddr[6:2])] == $past(pwdata[0]))
      else $error("io bit not driven");
   soft_rst_a: assert property (wacc && mode_reg && paddr == 12'h03C && !pwdata[0] |=>
      user_indicator && io_oe == 15'h0000)
      else $error("soft reset missed");
   mode_read_a: assert property (setup && !pwrite && paddr == 12'h080 |=> prdata[0] == mode_reg)
      else $error("mode bit wrong");
   zero_load_a: assert property (wacc && mode_reg && paddr == 12'h080 && pwdata[14:0] == 15'h0001 |=>
      ##1 !interrupt_request_flag)
      else $error("request after zero load");
   mask_off_a: assert property (wacc && !mode_reg && paddr == 12'h00C && !pwdata[0] |=>
      ##1 !interrupt_request_flag)
      else $error("request after mask clear");
   cover property (wacc && mode_reg && paddr == 12'h03C);
   cover property ($rose(interrupt_request_flag));
   cover property (!io_reset_in_n [*4]);
endmodule // cit_timer_chk
bind cit_timer cit_timer_chk cit_timer_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .io_reset_in_n(io_reset_in_n), .user_indicator(user_indicator),
   .interrupt_request_flag(interrupt_request_flag), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// ### sim/cit_pin_env.sv
// pin side: pulled-up irq lines, shared pins follow driven i/o bits
// assumes io_out and io_oe of the timer block
`timescale 1ns/1ps
`default_nettype none
module cit_pin_env (
   input wire logic [31:17] io_out,
   input wire logic [31:17] io_oe,
   output wire logic [15:1] irq_input_n
);
   genvar j;
   for (j = 1; j < 16; j = j + 1) begin : g_pin
      if (j < 7) begin : g_free
         assign irq_input_n[j] = 1'b1;
      end else begin : g_shr
         assign irq_input_n[j] = io_oe[38 - j] ? io_out[38 - j] : 1'b1;
      end
   end
endmodule // cit_pin_env
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the bit-addressed timer
// assumes apb slave with one access cycle; pins from cit_pin_env
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, io_reset_in_n;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire [31:0] prdata;
   wire pready, pslverr, user_indicator, interrupt_request_flag;
   wire [15:1] irq_input_n;
   wire [31:17] io_out, io_oe;
   logic [32:0] exp_q[$], msk_q[$];
   logic [5:0] ev;
   logic [13:0] lv;
   int num_errors = 0, n_checks = 0, seed = 70738, i, b;
   cit_timer cit_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_input_n(irq_input_n), .io_reset_in_n(io_reset_in_n), .user_indicator(user_indicator),
      .interrupt_request_flag(interrupt_request_flag), .io_out(io_out), .io_oe(io_oe));
   cit_pin_env cit_pin_env_inst (.io_out(io_out), .io_oe(io_oe), .irq_input_n(irq_input_n));
   // ----------------
   // bus and check tasks
   // ----------------
   task cmp(input [32:0] got, input [32:0] want);
      n_checks++;
      if (got !== want) begin
         num_errors++;
         $display("FAIL at %0t got %h want %h", $time, got, want);
      end
   endtask
   task apb(input [11:0] a, input [31:0] d, input w);
      psel <= 1'b1;
      paddr <= a;
      pwdata <= d;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input [11:0] a, input d);
      apb(a, {31'h0000_0000, d}, 1'b1);
   endtask
   task rd(input [11:0] a, input [32:0] m, input [32:0] e);
      msk_q.push_back(m);
      exp_q.push_back(e);
      apb(a, 32'h0000_0000, 1'b0);
   endtask
   // long waits end on the request, bounded at 400 clocks, about two periods of a load of 3
   task waitf;
      @(posedge pclk);
      for (i = 0; i < 400 && interrupt_request_flag !== 1'b1; i++)
         @(posedge pclk);
   endtask
   task done(input int t);
      $display("test %0d finished", t);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // read results are taken off the queue as each read completes
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         cmp({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      conclude;
   end
   initial begin
      presetn = 1'b0;
      io_reset_in_n = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp({user_indicator, io_oe, interrupt_request_flag}, {1'b1, 15'h0000, 1'b0});
      done(1);
      wr(12'h000, 1'b1);
      apb(12'h080, 32'h0000_0007, 1'b1);
      wr(12'h000, 1'b0);
      wr(12'h000, 1'b1);
      repeat (300) @(posedge pclk);
      rd(12'h080, 33'h0_0000_FFFF, 33'h0_0000_0007);
      cmp(interrupt_request_flag, 1'b0);
      done(2);
      wr(12'h000, 1'b0);
      wr(12'h00C, 1'b1);
      waitf;
      cmp(interrupt_request_flag, 1'b1);
      wr(12'h000, 1'b1);
      rd(12'h03C, 33'h0_0000_0001, 33'h0_0000_0001);
      wr(12'h000, 1'b0);
      wr(12'h00C, 1'b1);
      waitf;
      cmp(interrupt_request_flag, 1'b1);
      wr(12'h00C, 1'b0);
      repeat (400) @(posedge pclk);
      cmp(interrupt_request_flag, 1'b0);
      wr(12'h00C, 1'b1);
      waitf;
      wr(12'h000, 1'b1);
      apb(12'h080, 32'h0000_0001, 1'b1);
      @(posedge pclk);
      cmp(interrupt_request_flag, 1'b0);
      done(3);
      wr(12'h040, 1'b0);
      cmp(user_indicator, 1'b0);
      rd(12'h080, 33'h0_0000_FFFF, 33'h0_0000_FFFE);
      done(4);
      for (b = 17; b < 23; b++) begin
         ev[b - 17] = 1'($random(seed));
         wr(12'(4 * b), ev[b - 17]);
      end
      cmp({io_oe[22:17], io_out[22:17]}, {6'h3F, ev});
      wr(12'h00C, 1'b1);
      apb(12'h080, 32'h0000_0007, 1'b1);
      wr(12'h03C, 1'b0);
      cmp({user_indicator, io_oe}, {1'b1, 15'h0000});
      waitf;
      cmp(interrupt_request_flag, 1'b1);
      done(5);
      wr(12'h040, 1'b0);
      io_reset_in_n <= 1'b0;
      repeat (4) @(posedge pclk);
      io_reset_in_n <= 1'b1;
      repeat (2) @(posedge pclk);
      cmp({user_indicator, interrupt_request_flag}, 2'b10);
      rd(12'h088, 33'h1_0000_0000, 33'h1_0000_0000);
      done(6);
      wr(12'h000, 1'b1);
      lv = 14'($random(seed)) | 14'h2000;
      for (b = 1; b < 15; b++)
         wr(12'(4 * b), lv[b - 1]);
      rd(12'h084, 33'h0_0000_3FFF, {19'h0_0000, lv});
      // first decrement lands 64 clocks after the load edge
      repeat (60) @(posedge pclk);
      rd(12'h084, 33'h0_0000_3FFF, {19'h0_0000, lv - 14'h0001});
      done(7);
      conclude;
   end
endmodule // tb_top
`default_nettype wire
